// ### design/cdmm_params.svh
// constants for the cpu data memory map block
`ifndef CDMM_PARAMS_SVH
`define CDMM_PARAMS_SVH

// special register space
`define CDMM_SPECIAL_BASE 8'h80
`define CDMM_ADDR_STACK_PTR 8'h81
`define CDMM_ADDR_DPTR_LOW 8'h82
`define CDMM_ADDR_DPTR_HIGH 8'h83
`define CDMM_ADDR_STATUS 8'hd0
`define CDMM_ADDR_ACCUM 8'he0
`define CDMM_ADDR_MULT 8'hf0

// scratch-pad bit area
`define CDMM_BIT_AREA_LO 8'h20
`define CDMM_BIT_AREA_HI 8'h2f

// reset values and the read value of unimplemented special addresses
`define CDMM_STACK_PTR_RESET 8'h07
`define CDMM_REG_RESET 8'h00
`define CDMM_UNIMPL_READ 8'hff

// status word bank-select field
`define CDMM_BANK_MSB 4
`define CDMM_BANK_LSB 3

// stack step
`define CDMM_STACK_STEP 8'h01

`endif

// ### design/cdmm_pkg.sv
// types of the cpu data memory map block
package cdmm_pkg;

   // access mode from the instruction decoder
   typedef enum logic [1:0] {
      CDMM_MODE_DIRECT = 2'b00,
      CDMM_MODE_INDIRECT = 2'b01,
      CDMM_MODE_REGNUM = 2'b11,
      CDMM_MODE_BIT = 2'b10
   } cdmm_mode_t;

   // call sequencer
   typedef enum logic {
      CDMM_ST_IDLE = 1'b0,
      CDMM_ST_CALL_HI = 1'b1
   } cdmm_state_t;

endpackage : cdmm_pkg

// ### design/cdmm_core.sv
// data memory, working register banks, special registers and stack of the core
`timescale 1ns/100ps
`include "cdmm_params.svh"

module cdmm_core (
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // data access request
   input wire logic req_valid_in,
   input wire logic req_write_in,
   input wire cdmm_pkg::cdmm_mode_t req_mode_in,
   input wire logic [7:0] req_addr_in,
   input wire logic [7:0] req_wdata_in,
   input wire logic req_bit_in,
   // stack operations
   input wire logic push_in,
   input wire logic [7:0] push_data_in,
   input wire logic pop_in,
   input wire logic call_in,
   input wire logic [15:0] ret_addr_in,
   // answers and state
   output logic rd_valid_out,
   output logic [7:0] rd_data_out,
   output logic bit_data_out,
   output logic busy_out,
   output logic [7:0] stack_pointer_out,
   output logic [1:0] bank_select_bits_out,
   output logic [7:0] accumulator_main_out,
   output logic [7:0] status_word_out
);

   // helpers
   function automatic logic [7:0] bank_addr(input logic [1:0] bank, input logic [2:0] num);
      bank_addr = {3'b000, bank, num};
   endfunction : bank_addr

   function automatic logic [7:0] bit_byte_addr(input logic [7:0] bit_addr);
      if (bit_addr[7]) begin
         bit_byte_addr = {bit_addr[7:3], 3'b000};
      end else begin
         bit_byte_addr = `CDMM_BIT_AREA_LO + {4'h0, bit_addr[6:3]};
      end
   endfunction : bit_byte_addr

   // storage
   logic [7:0] ram [0:255];
   logic [7:0] stack_pointer_reg_q;
   logic [7:0] stack_pointer_reg_d;
   logic [7:0] status_word_q;
   logic [7:0] accumulator_main_q;
   logic [7:0] multiply_operand_reg_q;
   logic [7:0] data_pointer_low_q;
   logic [7:0] data_pointer_high_q;
   logic [15:0] ret_addr_q;
   cdmm_pkg::cdmm_state_t state_q;
   cdmm_pkg::cdmm_state_t state_d;
   logic rd_valid_q;
   logic [7:0] rd_data_q;
   logic bit_data_q;

   // operation arbitration
   wire idle = (state_q == cdmm_pkg::CDMM_ST_IDLE);
   wire do_call_hi = !idle;
   wire do_call_lo = idle && call_in;
   wire do_push = idle && !call_in && push_in;
   wire do_pop = idle && !call_in && !push_in && pop_in;
   wire do_req = idle && !call_in && !push_in && !pop_in && req_valid_in;

   // working register and pointer addressing
   wire [1:0] bank = status_word_q[`CDMM_BANK_MSB:`CDMM_BANK_LSB];
   wire [7:0] reg_addr = bank_addr(bank, req_addr_in[2:0]);
   wire [7:0] ptr_slot = bank_addr(bank, {2'b00, req_addr_in[0]});
   wire [7:0] ptr_value = ram[ptr_slot];

   // effective address
   wire bit_mode = (req_mode_in == cdmm_pkg::CDMM_MODE_BIT);
   wire [7:0] bit_byte = bit_byte_addr(req_addr_in);
   wire [2:0] bit_idx = req_addr_in[2:0];
   wire [7:0] eff_addr = (req_mode_in == cdmm_pkg::CDMM_MODE_DIRECT) ? req_addr_in :
                         (req_mode_in == cdmm_pkg::CDMM_MODE_INDIRECT) ? ptr_value :
                         (req_mode_in == cdmm_pkg::CDMM_MODE_REGNUM) ? reg_addr :
                         bit_byte;
   wire direct_kind = (req_mode_in == cdmm_pkg::CDMM_MODE_DIRECT) || bit_mode;
   wire to_special = direct_kind && (eff_addr >= `CDMM_SPECIAL_BASE);

   // special register decode
   wire hit_sp = (eff_addr == `CDMM_ADDR_STACK_PTR);
   wire hit_dpl = (eff_addr == `CDMM_ADDR_DPTR_LOW);
   wire hit_dph = (eff_addr == `CDMM_ADDR_DPTR_HIGH);
   wire hit_psw = (eff_addr == `CDMM_ADDR_STATUS);
   wire hit_acc = (eff_addr == `CDMM_ADDR_ACCUM);
   wire hit_mul = (eff_addr == `CDMM_ADDR_MULT);
   wire special_hit = hit_sp || hit_dpl || hit_dph || hit_psw || hit_acc || hit_mul;
   wire [7:0] special_rd = hit_sp ? stack_pointer_reg_q :
                           hit_dpl ? data_pointer_low_q :
                           hit_dph ? data_pointer_high_q :
                           hit_psw ? status_word_q :
                           hit_acc ? accumulator_main_q :
                           hit_mul ? multiply_operand_reg_q :
                           `CDMM_UNIMPL_READ;

   // read and bit merge
   // a bit write rewrites the whole byte with one bit changed, in one cycle
   wire [7:0] byte_rd = to_special ? special_rd : ram[eff_addr];
   wire [7:0] bit_mask = 8'h01 << bit_idx;
   wire [7:0] bit_merged = req_bit_in ? (byte_rd | bit_mask) : (byte_rd & ~bit_mask);
   wire [7:0] wr_value = bit_mode ? bit_merged : req_wdata_in;
   wire req_wr = do_req && req_write_in;
   wire special_wr = req_wr && to_special;

   // stack path
   wire [7:0] sp_inc = stack_pointer_reg_q + `CDMM_STACK_STEP;
   wire [7:0] sp_dec = stack_pointer_reg_q - `CDMM_STACK_STEP;
   wire stack_wr = do_push || do_call_lo || do_call_hi;
   wire [7:0] stack_data = do_push ? push_data_in :
                           do_call_lo ? ret_addr_in[7:0] :
                           ret_addr_q[15:8];
   wire [7:0] pop_byte = ram[stack_pointer_reg_q];

   // single RAM write port
   wire ram_we = stack_wr || (req_wr && !to_special);
   wire [7:0] ram_waddr = stack_wr ? sp_inc : eff_addr;
   wire [7:0] ram_wdata = stack_wr ? stack_data : wr_value;

   // next stack pointer
   always_comb begin
      stack_pointer_reg_d = stack_pointer_reg_q;
      if (stack_wr) begin
         stack_pointer_reg_d = sp_inc;
      end else if (do_pop) begin
         stack_pointer_reg_d = sp_dec;
      end else if (special_wr && hit_sp) begin
         stack_pointer_reg_d = wr_value;
      end
   end

   // call sequencer: low byte first, high byte next cycle
   always_comb begin
      case (state_q)
         cdmm_pkg::CDMM_ST_IDLE: begin
            state_d = call_in ? cdmm_pkg::CDMM_ST_CALL_HI : cdmm_pkg::CDMM_ST_IDLE;
         end
         cdmm_pkg::CDMM_ST_CALL_HI: begin
            state_d = cdmm_pkg::CDMM_ST_IDLE;
         end
         default: begin
            state_d = cdmm_pkg::CDMM_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (ram_we) begin
         ram[ram_waddr] <= ram_wdata;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         stack_pointer_reg_q <= `CDMM_STACK_PTR_RESET;
         state_q <= cdmm_pkg::CDMM_ST_IDLE;
         ret_addr_q <= {`CDMM_REG_RESET, `CDMM_REG_RESET};
      end else begin
         stack_pointer_reg_q <= stack_pointer_reg_d;
         state_q <= state_d;
         if (do_call_lo) begin
            ret_addr_q <= ret_addr_in;
         end
      end
   end

   // special register writes
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         status_word_q <= `CDMM_REG_RESET;
         accumulator_main_q <= `CDMM_REG_RESET;
         multiply_operand_reg_q <= `CDMM_REG_RESET;
         data_pointer_low_q <= `CDMM_REG_RESET;
         data_pointer_high_q <= `CDMM_REG_RESET;
      end else if (special_wr) begin
         if (hit_psw) status_word_q <= wr_value;
         if (hit_acc) accumulator_main_q <= wr_value;
         if (hit_mul) multiply_operand_reg_q <= wr_value;
         if (hit_dpl) data_pointer_low_q <= wr_value;
         if (hit_dph) data_pointer_high_q <= wr_value;
      end
   end

   // read answers
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         rd_valid_q <= 1'b0;
         rd_data_q <= `CDMM_REG_RESET;
         bit_data_q <= 1'b0;
      end else begin
         rd_valid_q <= do_pop || (do_req && !req_write_in);
         if (do_pop) begin
            rd_data_q <= pop_byte;
         end else if (do_req && !req_write_in) begin
            rd_data_q <= byte_rd;
            bit_data_q <= byte_rd[bit_idx];
         end
      end
   end

   assign rd_valid_out = rd_valid_q;
   assign rd_data_out = rd_data_q;
   assign bit_data_out = bit_data_q;
   assign busy_out = state_q;
   assign stack_pointer_out = stack_pointer_reg_q;
   assign bank_select_bits_out = status_word_q[`CDMM_BANK_MSB:`CDMM_BANK_LSB];
   assign accumulator_main_out = accumulator_main_q;
   assign status_word_out = status_word_q;

   // checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   chk_reset_sp_value: assert property (
      disable iff (1'b0) reset_in |-> stack_pointer_reg_q == `CDMM_STACK_PTR_RESET)
      else $error("stack pointer not 07h during reset");

   chk_push_incr_store: assert property (
      do_push |=> (stack_pointer_reg_q == $past(sp_inc)) && (pop_byte == $past(push_data_in)))
      else $error("push did not increment then store");

   chk_pop_read_decr: assert property (
      do_pop |=> rd_valid_out && (rd_data_out == $past(pop_byte))
                 && (stack_pointer_reg_q == $past(sp_dec)))
      else $error("pop did not read then decrement");

   chk_call_two_pushes: assert property (
      do_call_lo |=> busy_out ##1 (!busy_out && pop_byte == $past(ret_addr_in[15:8], 2)
                 && stack_pointer_reg_q == $past(stack_pointer_reg_q, 2) + 8'h02))
      else $error("call did not push both return bytes");

   chk_unimpl_reads_ones: assert property (
      (do_req && !req_write_in && to_special && !special_hit) |=>
         rd_data_out == `CDMM_UNIMPL_READ)
      else $error("unimplemented special address not read as ones");

   chk_bank_window: assert property (
      (do_req && req_mode_in == cdmm_pkg::CDMM_MODE_REGNUM) |->
         (eff_addr == {3'b000, status_word_q[`CDMM_BANK_MSB:`CDMM_BANK_LSB],
                       req_addr_in[2:0]}))
      else $error("working register outside active bank window");

   chk_indirect_to_ram: assert property (
      (do_req && req_mode_in == cdmm_pkg::CDMM_MODE_INDIRECT) |-> !to_special)
      else $error("indirect access reached special space");

   chk_bit_area_range: assert property (
      (do_req && bit_mode && !req_addr_in[7]) |->
         (eff_addr >= `CDMM_BIT_AREA_LO && eff_addr <= `CDMM_BIT_AREA_HI))
      else $error("bit address outside bit area");

   chk_sp_wraps: assert property (
      (do_push && stack_pointer_reg_q == 8'hff) |=> stack_pointer_reg_q == 8'h00)
      else $error("stack pointer did not wrap");

   chk_sp_software_write: assert property (
      (special_wr && hit_sp) |=> stack_pointer_reg_q == $past(wr_value))
      else $error("stack pointer write lost");

   // data path checks
   chk_bit_write_single: assert property (
      (special_wr && bit_mode && hit_acc) |=>
         !(|((accumulator_main_q ^ $past(accumulator_main_q)) & ~$past(bit_mask)))
         && (accumulator_main_q[$past(bit_idx)] == $past(req_bit_in)))
      else $error("bit write disturbed other accumulator bits");

   chk_bit_row_base: assert property (
      (do_req && bit_mode && to_special) |->
         (eff_addr[7:3] == req_addr_in[7:3]) && !(|eff_addr[2:0]))
      else $error("special bit access left its row base");

   chk_direct_ram_write: assert property (
      (req_wr && req_mode_in == cdmm_pkg::CDMM_MODE_DIRECT && !to_special) |=>
         ram[$past(req_addr_in)] == $past(req_wdata_in))
      else $error("direct write missed scratch-pad RAM");

   chk_pointer_write: assert property (
      (req_wr && req_mode_in == cdmm_pkg::CDMM_MODE_INDIRECT) |=>
         ram[$past(ptr_value)] == $past(req_wdata_in))
      else $error("indirect write missed pointed location");

   chk_regnum_write: assert property (
      (req_wr && req_mode_in == cdmm_pkg::CDMM_MODE_REGNUM) |=>
         ram[{3'b000, $past(bank), $past(req_addr_in[2:0])}] == $past(req_wdata_in))
      else $error("working register write missed its bank");

   chk_nondirect_spares: assert property (
      (req_wr && (req_mode_in == cdmm_pkg::CDMM_MODE_INDIRECT
                  || req_mode_in == cdmm_pkg::CDMM_MODE_REGNUM)) |=>
         $stable(status_word_q) && $stable(accumulator_main_q) && $stable(stack_pointer_reg_q))
      else $error("non-direct write reached a special register");

   chk_unimpl_write: assert property (
      (special_wr && !special_hit) |=>
         $stable(status_word_q) && $stable(accumulator_main_q)
         && $stable(multiply_operand_reg_q) && $stable(stack_pointer_reg_q))
      else $error("write to unimplemented special address took effect");

   chk_stack_spares: assert property (
      stack_wr |=> $stable(status_word_q) && $stable(accumulator_main_q)
                   && $stable(multiply_operand_reg_q))
      else $error("stack write reached a special register");

   chk_busy_quiet: assert property (
      busy_out |=> !rd_valid_out && (stack_pointer_reg_q == $past(sp_inc)))
      else $error("request served during high-byte push");

   cov_call_seq: cover property (do_call_lo ##1 do_call_hi);
   cov_push_pop: cover property (do_push ##1 do_pop);
   cov_bit_special: cover property (do_req && bit_mode && to_special && req_write_in);
   cov_bank_three: cover property (do_req && bank == 2'b11);
   cov_indirect_high: cover property (req_wr && req_mode_in == cdmm_pkg::CDMM_MODE_INDIRECT
      && ptr_value >= `CDMM_SPECIAL_BASE);

endmodule : cdmm_core

// ### tb/cdmm_cpu_model.sv
// decoder and execution unit model driving the data memory map
`timescale 1ns/100ps
module cdmm_cpu_model (
   // clock
   input wire logic clk_in,
   // answers
   input wire logic rd_valid_in,
   input wire logic [7:0] rd_data_in,
   input wire logic bit_data_in,
   // requests
   output logic req_valid_out,
   output logic req_write_out,
   output cdmm_pkg::cdmm_mode_t req_mode_out,
   output logic [7:0] req_addr_out,
   output logic [7:0] req_wdata_out,
   output logic req_bit_out,
   output logic push_out,
   output logic [7:0] push_data_out,
   output logic pop_out,
   output logic call_out,
   output logic [15:0] ret_addr_out
);
   initial begin
      {req_valid_out, req_write_out, req_bit_out, push_out, pop_out, call_out} = 6'h00;
      req_mode_out = cdmm_pkg::CDMM_MODE_DIRECT;
      {req_addr_out, req_wdata_out, push_data_out, ret_addr_out} = 40'h0;
   end
   // one access held over its taking edge; released lines show inverted data
   task automatic acc(input logic w, input cdmm_pkg::cdmm_mode_t m, input logic [7:0] a,
         input logic [7:0] wd, input logic b, output logic [7:0] rd, output logic rb,
         output logic v);
      @(posedge clk_in) #1;
      {req_valid_out, req_write_out, req_bit_out} = {1'b1, w, b};
      req_mode_out = m;
      {req_addr_out, req_wdata_out} = {a, wd};
      @(posedge clk_in) #1;
      {req_valid_out, req_bit_out} = {1'b0, ~b};
      {req_addr_out, req_wdata_out} = {~a, ~wd};
      {v, rd, rb} = {rd_valid_in, rd_data_in, bit_data_in};
   endtask : acc
   // push, pop or call entry, one at a time
   task automatic stk(input logic p, input logic [7:0] pd, input logic po, input logic c,
         input logic [15:0] ra, output logic [7:0] rd, output logic v);
      @(posedge clk_in) #1;
      {push_out, pop_out, call_out} = {p, po, c};
      {push_data_out, ret_addr_out} = {pd, ra};
      @(posedge clk_in) #1;
      {push_out, pop_out, call_out} = 3'h0;
      {push_data_out, ret_addr_out} = {~pd, ~ra};
      {v, rd} = {rd_valid_in, rd_data_in};
   endtask : stk
endmodule : cdmm_cpu_model

// ### tb/tb_top.sv
// self-checking bench for the data memory map
`timescale 1ns/100ps
module tb_top;
   localparam cdmm_pkg::cdmm_mode_t md_dir = cdmm_pkg::CDMM_MODE_DIRECT;
   localparam cdmm_pkg::cdmm_mode_t md_ind = cdmm_pkg::CDMM_MODE_INDIRECT;
   localparam cdmm_pkg::cdmm_mode_t md_reg = cdmm_pkg::CDMM_MODE_REGNUM;
   localparam cdmm_pkg::cdmm_mode_t md_bit = cdmm_pkg::CDMM_MODE_BIT;
   logic clk_in, reset_in, rq_v, rq_w, rq_b, psh, pp, cl, rd_v, bit_d, busy, rb, v;
   cdmm_pkg::cdmm_mode_t rq_m;
   logic [7:0] rq_a, rq_d, psh_d, rdat, sp, accm, stat, rd, x, y, a;
   logic [1:0] bank;
   logic [15:0] ret, ra;
   int n_fail = 0;
   int checks_done = 0;
   int cycles = 0;

   cdmm_core i_dut (.clk_in(clk_in), .reset_in(reset_in), .req_valid_in(rq_v),
      .req_write_in(rq_w), .req_mode_in(rq_m), .req_addr_in(rq_a), .req_wdata_in(rq_d),
      .req_bit_in(rq_b), .push_in(psh), .push_data_in(psh_d), .pop_in(pp), .call_in(cl),
      .ret_addr_in(ret), .rd_valid_out(rd_v), .rd_data_out(rdat), .bit_data_out(bit_d),
      .busy_out(busy), .stack_pointer_out(sp), .bank_select_bits_out(bank),
      .accumulator_main_out(accm), .status_word_out(stat));
   cdmm_cpu_model i_cpu (.clk_in(clk_in), .rd_valid_in(rd_v), .rd_data_in(rdat),
      .bit_data_in(bit_d), .req_valid_out(rq_v), .req_write_out(rq_w), .req_mode_out(rq_m),
      .req_addr_out(rq_a), .req_wdata_out(rq_d), .req_bit_out(rq_b), .push_out(psh),
      .push_data_out(psh_d), .pop_out(pp), .call_out(cl), .ret_addr_out(ret));

   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : close_out
   task automatic wr(input cdmm_pkg::cdmm_mode_t m, input logic [7:0] ad, input logic [7:0] d);
      i_cpu.acc(1'b1, m, ad, d, d[0], rd, rb, v);
   endtask : wr
   task automatic rdm(input cdmm_pkg::cdmm_mode_t m, input logic [7:0] ad);
      i_cpu.acc(1'b0, m, ad, 8'h00, 1'b0, rd, rb, v);
      check("read answer", v, 1'b1);
   endtask : rdm
   task automatic stk(input logic p, input logic po, input logic [7:0] d);
      i_cpu.stk(p, d, po, 1'b0, 16'h0000, rd, v);
   endtask : stk
   // bank register address and bit-area byte address
   function automatic logic [7:0] reg_addr(input logic [1:0] b, input logic [2:0] r);
      return {3'h0, b, r};
   endfunction : reg_addr
   function automatic logic [7:0] bit_byte(input logic [7:0] ba);
      return ba[7] ? {ba[7:3], 3'h0} : 8'h20 + {4'h0, ba[6:3]};
   endfunction : bit_byte

   always @(posedge clk_in) begin
      cycles++;
      if (cycles > 3000) begin
         n_fail++;
         close_out();
      end
   end

   initial begin
      reset_in = 1'b1;
      void'($urandom(87843));
      repeat (20) @(posedge clk_in);
      #1 reset_in = 1'b0;
      check("sp reset", sp, 8'h07);
      $display("test reset done");
      x = 8'($urandom);
      wr(md_dir, 8'he0, x);
      rdm(md_dir, 8'he0);
      check("accumulator", rd, x);
      wr(md_dir, 8'h84, x);
      rdm(md_dir, 8'h84);
      check("unimplemented", rd, 8'hff);
      rdm(md_bit, 8'h8a);
      check("unimplemented bit", bit_d, 1'b1);
      wr(md_reg, 8'h00, 8'he0);
      wr(md_ind, 8'h00, ~x);
      rdm(md_ind, 8'h00);
      check("indirect", rd, 8'(~x));
      check("acc untouched", accm, x);
      $display("test special and indirect done");
      for (int b = 0; b < 4; b++) begin
         wr(md_dir, 8'hd0, {3'h0, b[1:0], 3'h0});
         check("bank", bank, b[1:0]);
         check("status", stat, {3'h0, b[1:0], 3'h0});
         x = 8'($urandom);
         wr(md_reg, 8'h05, x);
         rdm(md_dir, reg_addr(b[1:0], 3'h5));
         check("bank ram", rd, x);
         rdm(md_reg, 8'h05);
         check("regnum", rd, x);
      end
      wr(md_dir, 8'hd0, 8'h00);
      $display("test banks done");
      for (int i = 0; i < 4; i++) begin
         a = (i < 2) ? {1'b0, 7'($urandom)} : (i == 2 ? 8'he5 : 8'hf7);
         wr(md_dir, bit_byte(a), 8'h00);
         wr(md_bit, a, 8'h01);
         rdm(md_dir, bit_byte(a));
         check("bit byte", rd, 8'h01 << a[2:0]);
         rdm(md_bit, a);
         check("bit read", bit_d, 1'b1);
      end
      $display("test bits done");
      wr(md_dir, 8'h81, 8'hfe);
      check("sp write", sp, 8'hfe);
      x = 8'($urandom);
      y = 8'($urandom);
      stk(1'b1, 1'b0, x);
      stk(1'b1, 1'b0, y);
      check("sp wrap", sp, 8'h00);
      wr(md_reg, 8'h01, 8'hff);
      rdm(md_ind, 8'h01);
      check("pushed byte", rd, x);
      stk(1'b0, 1'b1, 8'h00);
      check("pop byte", rd, y);
      check("pop sp", sp, 8'hff);
      ra = 16'($urandom);
      i_cpu.stk(1'b0, 8'h00, 1'b0, 1'b1, ra, rd, v);
      check("call busy", busy, 1'b1);
      stk(1'b0, 1'b1, 8'h00);
      check("ret high", rd, ra[15:8]);
      stk(1'b0, 1'b1, 8'h00);
      check("ret low", rd, ra[7:0]);
      check("sp after", sp, 8'hff);
      $display("test stack done");
      close_out();
   end
endmodule : tb_top
